//--- src/mode_ctrl_defs.svh
// offsets, field positions, reset values and widths of the mode registers
`ifndef MODE_CTRL_DEFS_SVH
`define MODE_CTRL_DEFS_SVH
`define ADDR_DISPLAY_MODE      4'h0
`define ADDR_RENDERING_MODE    4'h1
`define ADDR_CONVERSION_MODE   4'h2
`define ADDR_IMAGE_WIDTH       4'h3
`define ADDR_IMAGE_HEIGHT      4'h4
`define ADDR_MODE_STATUS       4'h5
`define BIT_BACKGROUND         10
`define BIT_DOT_DIV            8
`define BIT_SYNC_HI            7
`define BIT_SYNC_LO            6
`define BIT_SCAN_HI            5
`define BIT_SCAN_LO            4
`define BIT_MEMORY_WIDTH       6
`define BIT_PIXEL_DEPTH        0
`define RST_BACKGROUND         1'b0
`define RST_SYNC_MODE          2'b10
`define RST_REFRESH            4'h8
`define SYNC_MASTER            2'b00
`define SYNC_SWITCH            2'b01
`define SYNC_EXTERNAL          2'b10
`define SCAN_NONINTERLACE      2'b00
`define SCAN_INTERLACE         2'b10
`define SCAN_INTERLACE_VIDEO   2'b11
`define CONV_NORMAL            2'b00
`define CONV_DELTA             2'b01
`define CONV_PLAIN             2'b10
`define IMG_W_WIDTH            10
`define IMG_H_WIDTH            9
`define PIX_CNT_WIDTH          19
`endif

//--- src/mode_ctrl_pkg.sv
// types shared by the display and rendering mode controller
package mode_ctrl_pkg;
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

  typedef struct packed {
    logic        hsync_n;
    logic        vsync_n;
    logic        odd_field_n;
  } sync_pins_s;

  typedef struct packed {
    logic [8:0]  y;
    logic [9:0]  x;
  } coord_s;
endpackage : mode_ctrl_pkg

//--- src/display_render_mode_ctrl.sv
// mode register bank: display clocks, sync direction, scan, refresh, rendering map, colour conversion
// Notes on behaviour
// R1: background combine bit gates background, resets 0
// R2: divide clear: dot clock equals input, half-rate halves
// R3: divide set: dot clock halves, half-rate quarters
// R4: sync mode 00 drives sync pins out
// R5: switching mode halts display, pins input, clock held
// R6: software passes through switching mode between masters
// R7: sync mode 10 external sync inputs, reset value
// R8: scan 00 non-interlaced, switch every vertical cycle
// R9: scan 10 interlaced, switch every two cycles
// R10: scan 11 interlace video, switch every cycle
// R11: refresh field gives cycles per raster, reset 8
// R12: software avoids rendering changes while drawing
// R13: memory width and pixel depth survive reset
// R14: memory width selects 512 or 1024 pixels
// R15: pixel depth selects 8 or 16 bits
// R16: address Y upper, X upper, Y lower, X lower
// R17: supplier keeps X lower even in 8-bit mode
// R18: conversion 00 stores host data unchanged
// R19: conversion 10 converts luminance-chrominance to RGB
// R20: pixel count loads product, decrements, clears mode
// R21: conversion locks host memory, mode survives reset
// R22: delta-coded conversion also counts down and locks
// R23: delta uses code 01, plain uses 10
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "mode_ctrl_defs.svh"

module display_render_mode_ctrl (
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  input  wire mode_ctrl_pkg::reg_req_s reg_req,
  output logic [15:0]                 reg_rdata,
  input  wire logic                   display_clock_in,
  input  wire mode_ctrl_pkg::sync_pins_s sync_in,
  input  wire mode_ctrl_pkg::sync_pins_s sync_gen,
  output mode_ctrl_pkg::sync_pins_s   sync_out,
  output logic                        sync_oe_n,
  input  wire logic                   display_on,
  output logic                        display_active_out,
  output logic                        dot_clock_en,
  output logic                        dot_clock_out,
  output logic                        half_rate_clock_out,
  output logic                        background_combine,
  output logic                        interlace,
  output logic                        fb_switch_paired,
  output logic [3:0]                  refresh_cycles,
  output logic                        refresh_timing_en,
  input  wire mode_ctrl_pkg::coord_s  draw_coord,
  output logic [22:0]                 byte_addr,
  input  wire logic                   pixel_done,
  output logic                        conv_active,
  output logic                        conv_delta,
  output logic                        host_mem_lock
);
  import mode_ctrl_pkg::*;

  // retained fields: survive reset, so they sit outside the reset struct
  typedef struct packed {
    logic        dot_div;
    logic [1:0]  scan_mode;
    logic        memory_width;
    logic        pixel_depth;
    logic [1:0]  conv_mode;
    logic [`IMG_W_WIDTH-1:0] img_w;
    logic [`IMG_H_WIDTH-1:0] img_h;
    logic [`PIX_CNT_WIDTH-1:0] pix_cnt;
  } keep_s;

  typedef struct packed {
    logic        background_combine;
    logic [1:0]  sync_mode;
    logic [3:0]  refresh;
    logic [1:0]  clk_sync;
    logic        clk_prev;
    logic [1:0]  div_cnt;
    logic        dot_clk;
    logic        half_clk;
    logic        dot_en;
    logic [15:0] rdata;
  } state_s;

  state_s state_r, state_nxt;
  keep_s  keep_r, keep_nxt;
  logic   clk_edge;
  logic   clk_live;
  logic [`PIX_CNT_WIDTH-1:0] pix_product;

  assign pix_product = `PIX_CNT_WIDTH'(keep_r.img_w) * `PIX_CNT_WIDTH'(keep_r.img_h);
  // switching mode: the input clock is ignored as if held high
  assign clk_live = (state_r.sync_mode != `SYNC_SWITCH); // R5
  // both pin edges step the divider so the dot clock can match the pin rate;
  // the pin must stay under half of sys_clk for every edge to be seen
  assign clk_edge = clk_live && (state_r.clk_sync[1] != state_r.clk_prev);

  always_comb begin
    state_nxt = state_r;
    keep_nxt  = keep_r;
    state_nxt.clk_sync = {state_r.clk_sync[0], display_clock_in};
    state_nxt.clk_prev = state_r.clk_sync[1];
    state_nxt.dot_en   = 1'b0;
    if (clk_edge) begin
      state_nxt.div_cnt = state_r.div_cnt + 2'h1;
      if (!keep_r.dot_div) begin
        // input rate as dot clock, half rate on the slower output
        state_nxt.dot_en   = state_r.div_cnt[0]; // R2
        state_nxt.dot_clk  = ~state_r.dot_clk; // R2
        state_nxt.half_clk = state_r.div_cnt[0] ? ~state_r.half_clk : state_r.half_clk; // R2
      end else begin
        state_nxt.dot_en   = (state_r.div_cnt == 2'h3); // R3
        state_nxt.dot_clk  = state_r.div_cnt[0] ? ~state_r.dot_clk : state_r.dot_clk; // R3
        state_nxt.half_clk = (state_r.div_cnt == 2'h3) ? ~state_r.half_clk : state_r.half_clk; // R3
      end
    end
    // pixel countdown; set of a new mode below overrides an expiry
    if (keep_r.conv_mode != `CONV_NORMAL && pixel_done) begin
      if (keep_r.pix_cnt <= `PIX_CNT_WIDTH'(1)) begin
        keep_nxt.pix_cnt   = '0; // R20
        keep_nxt.conv_mode = `CONV_NORMAL; // R20 R22
      end else begin
        keep_nxt.pix_cnt = keep_r.pix_cnt - `PIX_CNT_WIDTH'(1); // R20
      end
    end
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        `ADDR_DISPLAY_MODE: begin
          state_nxt.background_combine = reg_req.wdata[`BIT_BACKGROUND]; // R1
          keep_nxt.dot_div             = reg_req.wdata[`BIT_DOT_DIV];
          // code 11 is prohibited; keep the old mode rather than store it
          if (reg_req.wdata[`BIT_SYNC_HI:`BIT_SYNC_LO] != 2'b11)
            state_nxt.sync_mode = reg_req.wdata[`BIT_SYNC_HI:`BIT_SYNC_LO]; // R7
          if (reg_req.wdata[`BIT_SCAN_HI:`BIT_SCAN_LO] != 2'b01)
            keep_nxt.scan_mode = reg_req.wdata[`BIT_SCAN_HI:`BIT_SCAN_LO]; // R8
          state_nxt.refresh = reg_req.wdata[3:0]; // R11
        end
        `ADDR_RENDERING_MODE: begin
          keep_nxt.memory_width = reg_req.wdata[`BIT_MEMORY_WIDTH]; // R14
          keep_nxt.pixel_depth  = reg_req.wdata[`BIT_PIXEL_DEPTH]; // R15
        end
        `ADDR_CONVERSION_MODE: begin
          if (reg_req.wdata[1:0] != 2'b11) begin
            keep_nxt.conv_mode = reg_req.wdata[1:0]; // R18 R23
            keep_nxt.pix_cnt   = pix_product; // R20
          end
        end
        `ADDR_IMAGE_WIDTH:  keep_nxt.img_w = reg_req.wdata[`IMG_W_WIDTH-1:0];
        `ADDR_IMAGE_HEIGHT: keep_nxt.img_h = reg_req.wdata[`IMG_H_WIDTH-1:0];
        default: ;
      endcase
    end
    state_nxt.rdata = 16'h0000;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        `ADDR_DISPLAY_MODE:
          state_nxt.rdata = {5'h00, state_r.background_combine, 1'b0, keep_r.dot_div,
                             state_r.sync_mode, keep_r.scan_mode, state_r.refresh};
        `ADDR_RENDERING_MODE:
          state_nxt.rdata = {9'h000, keep_r.memory_width, 5'h00, keep_r.pixel_depth};
        `ADDR_CONVERSION_MODE: state_nxt.rdata = {14'h0000, keep_r.conv_mode};
        `ADDR_IMAGE_WIDTH:     state_nxt.rdata = {6'h00, keep_r.img_w};
        `ADDR_IMAGE_HEIGHT:    state_nxt.rdata = {7'h00, keep_r.img_h};
        `ADDR_MODE_STATUS:     state_nxt.rdata = keep_r.pix_cnt[15:0];
        default:               state_nxt.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= '0;
      state_r.background_combine <= `RST_BACKGROUND; // R1
      state_r.sync_mode <= `RST_SYNC_MODE; // R7
      state_r.refresh <= `RST_REFRESH; // R11
    end else begin
      state_r <= state_nxt;
    end
  end

  // no reset: these fields hold their value through a reset
  always_ff @(posedge sys_clk) begin
    keep_r <= keep_nxt; // R13 R21
  end

  assign reg_rdata           = state_r.rdata;
  assign background_combine  = state_r.background_combine; // R1
  assign dot_clock_en        = state_r.dot_en;
  assign dot_clock_out       = state_r.dot_clk;
  assign half_rate_clock_out = state_r.half_clk;
  assign sync_oe_n           = (state_r.sync_mode != `SYNC_MASTER); // R4 R5 R7
  assign sync_out            = sync_gen;
  assign display_active_out  = display_on && (state_r.sync_mode != `SYNC_SWITCH); // R5
  assign interlace           = keep_r.scan_mode[1]; // R9 R10
  assign fb_switch_paired    = (keep_r.scan_mode == `SCAN_INTERLACE); // R8 R9 R10
  assign refresh_cycles      = state_r.refresh; // R11
  assign refresh_timing_en   = (state_r.refresh != 4'h0); // R11
  assign conv_active         = (keep_r.conv_mode != `CONV_NORMAL); // R19 R22
  assign conv_delta          = (keep_r.conv_mode == `CONV_DELTA); // R23
  assign host_mem_lock       = conv_active; // R21

  // Y upper, X upper, Y lower, X lower; A0 forced zero at 16 bits
  always_comb begin
    if (keep_r.memory_width)
      byte_addr = {draw_coord.y[8:3], draw_coord.x[9], draw_coord.y[2:0], draw_coord.x[8:0],
                   4'h0}; // R16
    else
      byte_addr = {draw_coord.y[8:3], 1'b0, draw_coord.y[2:0], draw_coord.x[8:0], 4'h0}; // R16
    if (!keep_r.pixel_depth)
      byte_addr[13:0] = {draw_coord.y[2:0], 1'b0, draw_coord.x[9:0]}; // R15 R17
    else
      byte_addr[0] = 1'b0; // R16
  end

  // host port events that the properties below start from
  sequence display_write_seq;
    reg_req.wr && reg_req.addr == `ADDR_DISPLAY_MODE;
  endsequence

  sequence rendering_write_seq;
    reg_req.wr && reg_req.addr == `ADDR_RENDERING_MODE;
  endsequence

  sequence conversion_write_seq;
    reg_req.wr && reg_req.addr == `ADDR_CONVERSION_MODE;
  endsequence

  // a converted pixel with no host write beside it; a conversion write of a code other than 11 would win
  sequence pixel_step_seq;
    conv_active && pixel_done && !reg_req.wr;
  endsequence

  // one synchronised pin edge outside switching mode
  sequence pin_edge_seq;
    clk_edge;
  endsequence

  sync_master_a: assert property (@(posedge sys_clk) disable iff (reset) // R4
    (state_r.sync_mode == `SYNC_MASTER) |->
      !sync_oe_n)
    else $error("sync pins not driven");

  switch_halt_a: assert property (@(posedge sys_clk) disable iff (reset) // R5
    (state_r.sync_mode == `SYNC_SWITCH) |->
      (!display_active_out && sync_oe_n && !state_nxt.dot_en))
    else $error("switch mode not halted");

  external_in_a: assert property (@(posedge sys_clk) disable iff (reset) // R7
    (state_r.sync_mode == `SYNC_EXTERNAL) |->
      sync_oe_n)
    else $error("external sync driven");

  sync_refuse_a: assert property (@(posedge sys_clk) disable iff (reset) // R7
    display_write_seq ##0 (reg_req.wdata[`BIT_SYNC_HI:`BIT_SYNC_LO] == 2'b11) |=>
      (state_r.sync_mode == $past(state_r.sync_mode)))
    else $error("prohibited sync code stored");

  sync_load_a: assert property (@(posedge sys_clk) disable iff (reset) // R4 R5 R7
    display_write_seq ##0 (reg_req.wdata[`BIT_SYNC_HI:`BIT_SYNC_LO] != 2'b11) |=>
      (state_r.sync_mode == $past(reg_req.wdata[`BIT_SYNC_HI:`BIT_SYNC_LO])))
    else $error("sync mode not loaded");

  switch_clock_a: assert property (@(posedge sys_clk) disable iff (reset) // R5
    (state_r.sync_mode == `SYNC_SWITCH) |=>
      ($stable(dot_clock_out) && $stable(half_rate_clock_out)))
    else $error("clocks ran in switch mode");

  refresh_load_a: assert property (@(posedge sys_clk) disable iff (reset) // R11
    display_write_seq |=>
      (refresh_cycles == $past(reg_req.wdata[3:0])))
    else $error("refresh count not loaded");

  refresh_off_a: assert property (@(posedge sys_clk) disable iff (reset) // R11
    display_write_seq ##0 (reg_req.wdata[3:0] == 4'h0) |=>
      !refresh_timing_en)
    else $error("refresh timing not suppressed");

  reg_write_a: assert property (@(posedge sys_clk) disable iff (reset) // R1
    display_write_seq |=>
      (background_combine == $past(reg_req.wdata[`BIT_BACKGROUND])))
    else $error("background lost");

  dot_div_load_a: assert property (@(posedge sys_clk) disable iff (reset) // R2 R3
    display_write_seq |=>
      (keep_r.dot_div == $past(reg_req.wdata[`BIT_DOT_DIV])))
    else $error("dot divide not loaded");

  scan_refuse_a: assert property (@(posedge sys_clk) disable iff (reset) // R8
    display_write_seq ##0 (reg_req.wdata[`BIT_SCAN_HI:`BIT_SCAN_LO] == 2'b01) |=>
      (keep_r.scan_mode == $past(keep_r.scan_mode)))
    else $error("prohibited scan code stored");

  scan_plain_a: assert property (@(posedge sys_clk) disable iff (reset) // R8
    (keep_r.scan_mode == `SCAN_NONINTERLACE) |->
      (!interlace && !fb_switch_paired))
    else $error("non-interlace scan wrong");

  scan_two_a: assert property (@(posedge sys_clk) disable iff (reset) // R9
    (keep_r.scan_mode == `SCAN_INTERLACE) |->
      (interlace && fb_switch_paired))
    else $error("interlace scan wrong");

  scan_video_a: assert property (@(posedge sys_clk) disable iff (reset) // R10
    (keep_r.scan_mode == `SCAN_INTERLACE_VIDEO) |->
      (interlace && !fb_switch_paired))
    else $error("interlace video scan wrong");

  dot_full_a: assert property (@(posedge sys_clk) disable iff (reset) // R2
    pin_edge_seq ##0 !keep_r.dot_div |=>
      (dot_clock_out != $past(dot_clock_out)))
    else $error("dot clock slower than pin");

  half_div_a: assert property (@(posedge sys_clk) disable iff (reset) // R2
    pin_edge_seq ##0 (!keep_r.dot_div && state_r.div_cnt[0]) |=>
      (dot_clock_en && half_rate_clock_out != $past(half_rate_clock_out)))
    else $error("dot enable missing");

  dot_slow_a: assert property (@(posedge sys_clk) disable iff (reset) // R3
    pin_edge_seq ##0 (keep_r.dot_div && !state_r.div_cnt[0]) |=>
      ($stable(dot_clock_out) && !dot_clock_en))
    else $error("divided dot clock too fast");

  quarter_a: assert property (@(posedge sys_clk) disable iff (reset) // R3
    pin_edge_seq ##0 (keep_r.dot_div && state_r.div_cnt == 2'h3) |=>
      (dot_clock_en && half_rate_clock_out != $past(half_rate_clock_out)))
    else $error("quarter rate step missing");

  render_load_a: assert property (@(posedge sys_clk) disable iff (reset) // R14 R15
    rendering_write_seq |=>
      (keep_r.memory_width == $past(reg_req.wdata[`BIT_MEMORY_WIDTH]) &&
       keep_r.pixel_depth == $past(reg_req.wdata[`BIT_PIXEL_DEPTH])))
    else $error("rendering mode not loaded");
  byte_lsb_a: assert property (@(posedge sys_clk) disable iff (reset) // R16
    keep_r.pixel_depth |->
      !byte_addr[0])
    else $error("byte lsb set at 16 bits");

  addr_top_a: assert property (@(posedge sys_clk) disable iff (reset) // R16
    1'b1 |->
      (byte_addr[22:17] == draw_coord.y[8:3]))
    else $error("Y upper not at the top");

  narrow_x_a: assert property (@(posedge sys_clk) disable iff (reset) // R14
    !keep_r.memory_width |->
      !byte_addr[16])
    else $error("X upper used at narrow width");

  conv_load_a: assert property (@(posedge sys_clk) disable iff (reset) // R20
    conversion_write_seq ##0 (reg_req.wdata[1:0] != 2'b11) |=>
      (keep_r.pix_cnt == $past(pix_product)))
    else $error("pixel count not loaded");

  conv_refuse_a: assert property (@(posedge sys_clk) disable iff (reset) // R18
    conversion_write_seq ##0 (reg_req.wdata[1:0] == 2'b11 && !pixel_done) |=>
      (keep_r.conv_mode == $past(keep_r.conv_mode)))
    else $error("prohibited conversion code stored");

  conv_lock_a: assert property (@(posedge sys_clk) disable iff (reset) // R21 R22
    conversion_write_seq ##0 (reg_req.wdata[1] != reg_req.wdata[0]) |=>
      (host_mem_lock && conv_active))
    else $error("memory not locked");

  conv_delta_a: assert property (@(posedge sys_clk) disable iff (reset) // R22 R23
    conversion_write_seq ##0 (reg_req.wdata[1:0] == `CONV_DELTA) |=>
      conv_delta)
    else $error("delta conversion not selected");

  conv_plain_a: assert property (@(posedge sys_clk) disable iff (reset) // R19 R23
    conversion_write_seq ##0 (reg_req.wdata[1:0] == `CONV_PLAIN) |=>
      (conv_active && !conv_delta))
    else $error("plain conversion not selected");

  conv_normal_a: assert property (@(posedge sys_clk) disable iff (reset) // R18
    conversion_write_seq ##0 (reg_req.wdata[1:0] == `CONV_NORMAL) |=>
      (!conv_active && !host_mem_lock))
    else $error("normal mode still converting");

  conv_step_a: assert property (@(posedge sys_clk) disable iff (reset) // R20
    pixel_step_seq ##0 (keep_r.pix_cnt > `PIX_CNT_WIDTH'(1)) |=>
      (conv_active && keep_r.pix_cnt == $past(keep_r.pix_cnt) - `PIX_CNT_WIDTH'(1)))
    else $error("pixel count not decremented");

  conv_end_a: assert property (@(posedge sys_clk) disable iff (reset) // R20 R22
    pixel_step_seq ##0 (keep_r.pix_cnt <= `PIX_CNT_WIDTH'(1)) |=>
      !conv_active)
    else $error("conversion did not end");

  conv_hold_a: assert property (@(posedge sys_clk) disable iff (reset) // R20
    (conv_active && !pixel_done && !reg_req.wr) |=>
      ($stable(keep_r.pix_cnt) && conv_active))
    else $error("pixel count moved without a pixel");
endmodule : display_render_mode_ctrl

//--- testbench/video_source_model.sv
// external video source: display clock pin and sync pins for tv sync mode
`timescale 1ns/1ps
module video_source_model (
  input  wire logic                  run,
  output logic                       display_clock_in,
  output mode_ctrl_pkg::sync_pins_s  ext_sync
);
  import mode_ctrl_pkg::*;
  // 12.5 MHz, well under the synchroniser limit; a stopped clock parks high
  initial begin
    display_clock_in = 1'b1;
    ext_sync = 3'h5;
    forever begin
      #40 display_clock_in = run ? ~display_clock_in : 1'b1;
      if (display_clock_in) ext_sync = ~ext_sync;
    end
  end
endmodule : video_source_model

//--- testbench/display_render_mode_ctrl_tb.sv
// self-checking bench for the display and rendering mode register bank
`timescale 1ns/1ps
`include "mode_ctrl_defs.svh"
module display_render_mode_ctrl_tb;
  import mode_ctrl_pkg::*;
  logic        sys_clk = 0, reset = 1, display_on = 0, pixel_done = 0, run = 1, cnt_on = 0;
  reg_req_s    reg_req = '0;
  sync_pins_s  sync_gen = '0, sync_in, sync_out, ext_sync;
  coord_s      draw_coord = '0;
  logic        display_clock_in, sync_oe_n, display_active_out, dot_clock_en, dot_clock_out;
  logic        half_rate_clock_out, background_combine, interlace, fb_switch_paired, refresh_timing_en;
  logic        conv_active, conv_delta, host_mem_lock;
  logic [3:0]  refresh_cycles, rf;
  logic [15:0] reg_rdata, rv, seed = 16'h000e;
  logic [22:0] byte_addr;
  logic [1:0]  sc;
  logic [1:0]  syq [5] = '{2'b10, 2'b01, 2'b00, 2'b01, 2'b10};
  logic [1:0]  scq [3] = '{2'b00, 2'b10, 2'b11};
  logic [15:0] rmq [4] = '{16'h0000, 16'h0040, 16'h0001, 16'h0041};
  int          n_fail = 0, total_checks = 0, nd, nh, e;

  // the pin level: the device wins only while its enable is low
  assign sync_in = sync_oe_n ? ext_sync : sync_out;

  display_render_mode_ctrl u_display_render_mode_ctrl (.sys_clk, .reset, .reg_req, .reg_rdata,
    .display_clock_in, .sync_in, .sync_gen, .sync_out, .sync_oe_n, .display_on, .display_active_out,
    .dot_clock_en, .dot_clock_out, .half_rate_clock_out, .background_combine, .interlace,
    .fb_switch_paired, .refresh_cycles, .refresh_timing_en, .draw_coord, .byte_addr, .pixel_done,
    .conv_active, .conv_delta, .host_mem_lock);
  video_source_model u_video_source_model (.run, .display_clock_in, .ext_sync);

  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge dot_clock_out) if (cnt_on) nd++;
  always @(posedge half_rate_clock_out) if (cnt_on) nh++;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [15:0] dm(input logic b, d, input logic [1:0] sy, scn, input logic [3:0] r);
    return {5'h00, b, 1'b0, d, sy, scn, r};
  endfunction : dm
  task automatic check(input logic [31:0] seen, exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_req.addr <= a;
    reg_req.wdata <= d;
    reg_req.wr <= 1'b1;
    @(posedge sys_clk);
    reg_req.wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_req.addr <= a;
    reg_req.rd <= 1'b1;
    @(posedge sys_clk);
    reg_req.rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    rd(`ADDR_DISPLAY_MODE, rv);
    check(rv & 16'h04cf, 16'h0088, "display_mode reset");
    check({sync_oe_n, background_combine, refresh_cycles}, 6'h28, "reset pins");
    foreach (syq[i]) begin
      seed = lfsr(seed);
      sc = scq[i % 3];
      rf = (i == 1) ? 4'h0 : (i == 2) ? 4'hf : seed[3:0];
      display_on <= seed[6];
      sync_gen <= seed[9:7];
      run <= (syq[i] != `SYNC_SWITCH);
      wr(`ADDR_DISPLAY_MODE, dm(seed[4], seed[5], syq[i], sc, rf));
      rd(`ADDR_DISPLAY_MODE, rv);
      check(rv, dm(seed[4], seed[5], syq[i], sc, rf), "display_mode");
      check(sync_oe_n, syq[i] != `SYNC_MASTER, "sync direction");
      check(display_active_out, seed[6] && syq[i] != `SYNC_SWITCH, "display active");
      check({interlace, fb_switch_paired}, {sc[1], sc == `SCAN_INTERLACE}, "scan");
      check({refresh_timing_en, refresh_cycles, background_combine}, {rf != 0, rf, seed[4]}, "refresh");
      if (syq[i] == `SYNC_MASTER) check(sync_out, seed[9:7], "sync out");
    end
    // codes that may not be programmed leave the field as it was
    wr(`ADDR_DISPLAY_MODE, dm(1'b0, 1'b0, 2'b11, 2'b01, 4'h5));
    rd(`ADDR_DISPLAY_MODE, rv);
    check(rv, dm(1'b0, 1'b0, `SYNC_EXTERNAL, `SCAN_INTERLACE, 4'h5), "refused codes");
    rd(4'hf, rv);
    check(rv, 16'h0000, "unmapped read");
    for (int dv = 0; dv < 2; dv++) begin
      wr(`ADDR_DISPLAY_MODE, dm(1'b0, dv[0], `SYNC_EXTERNAL, `SCAN_NONINTERLACE, 4'h8));
      repeat (20) @(posedge sys_clk);
      nd = 0;
      nh = 0;
      cnt_on = 1;
      repeat (32) @(posedge display_clock_in);
      cnt_on = 0;
      e = 32 >> dv;
      check(nd >= e - 1 && nd <= e + 1, 1'b1, "dot clock rate");
      check(nh >= e / 2 - 1 && nh <= e / 2 + 1, 1'b1, "half rate clock");
    end
    foreach (rmq[i]) begin
      seed = lfsr(seed);
      wr(`ADDR_RENDERING_MODE, rmq[i]);
      rd(`ADDR_RENDERING_MODE, rv);
      check(rv, rmq[i], "rendering_mode");
    end
    draw_coord <= {seed[8:0], seed[15:7], 1'b0};
    #20 check(byte_addr[0], 1'b0, "byte address lsb");
    check(byte_addr[22:16], {seed[8:3], seed[15]}, "byte address top");
    wr(`ADDR_IMAGE_WIDTH, 16'h0003);
    wr(`ADDR_IMAGE_HEIGHT, 16'h0002);
    for (int m = 1; m < 3; m++) begin
      wr(`ADDR_CONVERSION_MODE, 16'(m));
      check({conv_active, conv_delta, host_mem_lock}, {1'b1, m == 1, 1'b1}, "conversion on");
      rd(`ADDR_MODE_STATUS, rv);
      check(rv, 16'h0006, "pixel count loaded");
      repeat (6) begin
        check(conv_active, 1'b1, "conversion counting");
        @(posedge sys_clk);
        pixel_done <= 1'b1;
        @(posedge sys_clk);
        pixel_done <= 1'b0;
        #1;
      end
      repeat (2) @(posedge sys_clk);
      rd(`ADDR_CONVERSION_MODE, rv);
      check({rv, conv_active, host_mem_lock}, 18'h0, "conversion done");
    end
    wr(`ADDR_CONVERSION_MODE, 16'h0003);
    rd(`ADDR_CONVERSION_MODE, rv);
    check(rv, 16'h0000, "refused conversion code");
    wr(`ADDR_DISPLAY_MODE, dm(1'b1, 1'b0, `SYNC_SWITCH, `SCAN_NONINTERLACE, 4'h3));
    wr(`ADDR_CONVERSION_MODE, 16'h0002);
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rd(`ADDR_DISPLAY_MODE, rv);
    check(rv & 16'h04cf, 16'h0088, "display_mode second reset");
    rd(`ADDR_RENDERING_MODE, rv);
    check(rv, 16'h0041, "rendering kept");
    rd(`ADDR_CONVERSION_MODE, rv);
    check(rv, 16'h0002, "conversion kept");
    wr(`ADDR_CONVERSION_MODE, 16'h0000);
    tally_and_finish();
  end
endmodule : display_render_mode_ctrl_tb
